// File: pcg_pkg.sv
// package: register map, field layout and timing constants of the power-save clock manager
`default_nettype none
package pcg_pkg;
  // ***************************************
  // register map
  // ***************************************
  localparam logic [3:0]  PCG_CLOCK_DIVIDER_OFS = 4'h0;
  localparam logic [3:0]  PCG_GATE_ONE_OFS      = 4'h4;
  localparam logic [3:0]  PCG_STATUS_OFS        = 4'h8;
  // ***************************************
  // clock divider register fields
  // ***************************************
  localparam int          PCG_RESTORE_BIT       = 15;
  localparam int          PCG_RATIO_MSB         = 14;
  localparam int          PCG_RATIO_LSB         = 12;
  localparam int          PCG_SLOWDOWN_BIT      = 11;
  localparam logic [2:0]  PCG_RATIO_RESET       = 3'h0;
  // ***************************************
  // gate register fields
  // ***************************************
  localparam logic [15:0] PCG_GATE_RESET        = 16'h0000;
  localparam logic [15:0] PCG_GATE_WMASK        = 16'hfeff;
  localparam int          PCG_ADC_GATE_BIT      = 0;
  // ***************************************
  // status register fields
  // ***************************************
  localparam int          PCG_ST_DOZE_BIT       = 4;
  localparam int          PCG_ST_WAKE_IRQ_BIT   = 3;
  localparam int          PCG_ST_WAKE_WDT_BIT   = 2;
  // ***************************************
  // timing
  // ***************************************
  localparam int          PCG_CLOCK_MHZ         = 100;
  localparam int          PCG_INSTR_CYCLES      = 1;
  localparam int          PCG_WAKE_MIN_CYCLES   = 2;
  localparam int          PCG_WAKE_MAX_CYCLES   = 4;
  localparam logic [1:0]  PCG_WAKE_DELAY        = 2'h3;
  localparam logic [6:0]  PCG_DOZE_CNT_RESET    = 7'h00;
  // ***************************************
  // power-save modes and states
  // ***************************************
  typedef enum logic {
    PCG_MODE_SLEEP = 1'b0,
    PCG_MODE_IDLE  = 1'b1
  } pcg_mode_t;
  typedef enum logic [2:0] {
    PCG_ST_RUN   = 3'b000,
    PCG_ST_ENTER = 3'b001,
    PCG_ST_SLEEP = 3'b010,
    PCG_ST_IDLE  = 3'b011,
    PCG_ST_WAKE  = 3'b100
  } pcg_state_t;
endpackage
`default_nettype wire

// File: pcg_power_save_clock_gating.sv
// module: sleep, idle, doze and per-peripheral clock gating with an Avalon-MM register slave
`default_nettype none
module pcg_power_save_clock_gating #(
  parameter logic [15:0] PRESENT_MASK = 16'hfeff
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                nrst,
  // avalon-mm slave
  input  wire logic [3:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  input  wire logic [3:0]          byteenable,
  output logic [31:0]              readdata,
  output logic                     waitrequest,
  // cpu side
  input  wire logic                power_save_instruction,
  input  wire pcg_pkg::pcg_mode_t  power_save_mode,
  input  wire logic                irq_pending,
  input  wire logic [2:0]          clock_source,
  output logic                     cpu_clk_en,
  output logic                     cpu_halted,
  output logic                     resume_to_isr,
  output logic [2:0]               resume_clock_source,
  // watchdog and oscillators
  input  wire logic                watchdog_timer_enable,
  input  wire logic                watchdog_timer_timeout,
  input  wire logic                clock_fail_monitor_enable,
  output logic                     watchdog_timer_clear,
  output logic                     system_osc_en,
  output logic                     low_power_rc_oscillator_en,
  output logic                     clock_fail_monitor_active,
  // peripherals
  output logic                     periph_clk_en,
  output logic [15:0]              module_clock_en,
  output logic [15:0]              module_regs_en,
  input  wire logic [15:0]         analog_pin_config_bits,
  output logic [15:0]              analog_input_pins
);
  import pcg_pkg::*;

  // ***************************************
  // registers
  // ***************************************
  pcg_state_t  state_reg;
  pcg_state_t  state_next;
  logic        restore_reg;
  logic [2:0]  ratio_reg;
  logic        slowdown_reg;
  logic [15:0] gate_reg;
  logic [15:0] gate_eff_reg;
  logic        held_irq_reg;
  logic        wake_irq_reg;
  logic        wake_wdt_reg;
  logic [1:0]  wake_cnt_reg;
  logic [6:0]  doze_cnt_reg;
  logic [2:0]  source_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        clr_wdt_reg;
  logic        wr_div;
  logic        wr_gate;
  logic        wake_event;
  logic        doze_tick;
  logic [6:0]  doze_limit;

  // ***************************************
  // avalon-mm slave
  // ***************************************
  // fixed one wait state: request taken on the edge where ack_reg is high
  assign waitrequest = (read | write) & ~ack_reg;
  assign readdata    = rdata_reg;
  assign wr_div      = write & ack_reg & (address == PCG_CLOCK_DIVIDER_OFS) & byteenable[1];
  assign wr_gate     = write & ack_reg & (address == PCG_GATE_ONE_OFS);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (read & ~ack_reg) begin
      unique case (address)
        PCG_CLOCK_DIVIDER_OFS: rdata_reg <= {16'h0000, restore_reg, ratio_reg, slowdown_reg, 11'h000};
        PCG_GATE_ONE_OFS:      rdata_reg <= {16'h0000, gate_reg};
        PCG_STATUS_OFS:        rdata_reg <= {27'h0000000, slowdown_reg, wake_irq_reg, wake_wdt_reg,
                                             state_reg == PCG_ST_IDLE, state_reg == PCG_ST_SLEEP};
        default:               rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ***************************************
  // doze control
  // ***************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      restore_reg <= 1'b0;
      ratio_reg   <= PCG_RATIO_RESET;
    end else if (wr_div) begin
      restore_reg <= writedata[PCG_RESTORE_BIT];
      ratio_reg   <= writedata[PCG_RATIO_MSB:PCG_RATIO_LSB];
    end
  end

  // hardware clear wins over a software set in the same cycle, so an
  // interrupt is never left running at the slow rate while restore_reg is set
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slowdown_reg <= 1'b0;
    end else if (restore_reg & irq_pending) begin
      slowdown_reg <= 1'b0;
    end else if (wr_div) begin
      slowdown_reg <= writedata[PCG_SLOWDOWN_BIT];
    end
  end

  assign doze_limit = 7'((8'h01 << ratio_reg) - 8'h01);
  assign doze_tick  = (doze_cnt_reg == doze_limit);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      doze_cnt_reg <= PCG_DOZE_CNT_RESET;
    end else if (doze_tick | ~slowdown_reg) begin
      doze_cnt_reg <= PCG_DOZE_CNT_RESET;
    end else begin
      doze_cnt_reg <= doze_cnt_reg + 7'h01;
    end
  end

  // ***************************************
  // power-save state machine
  // ***************************************
  assign wake_event = irq_pending | held_irq_reg | watchdog_timer_timeout;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PCG_ST_RUN: begin
        if (power_save_instruction) begin
          state_next = PCG_ST_ENTER;
        end
      end
      PCG_ST_ENTER: begin
        state_next = (power_save_mode == PCG_MODE_SLEEP) ? PCG_ST_SLEEP : PCG_ST_IDLE;
      end
      PCG_ST_SLEEP: begin
        if (wake_event) begin
          state_next = PCG_ST_WAKE;
        end
      end
      PCG_ST_IDLE: begin
        if (wake_event) begin
          state_next = PCG_ST_WAKE;
        end
      end
      PCG_ST_WAKE: begin
        if (wake_cnt_reg == PCG_WAKE_DELAY - 2'h1) begin
          state_next = PCG_ST_RUN;
        end
      end
      default: state_next = PCG_ST_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= PCG_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // an interrupt seen during entry is kept until the mode is reached
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      held_irq_reg <= 1'b0;
    end else if (state_reg == PCG_ST_ENTER) begin
      held_irq_reg <= irq_pending;
    end else if (state_reg != PCG_ST_SLEEP && state_reg != PCG_ST_IDLE) begin
      held_irq_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wake_cnt_reg <= 2'h0;
    end else if (state_reg == PCG_ST_WAKE) begin
      wake_cnt_reg <= wake_cnt_reg + 2'h1;
    end else begin
      wake_cnt_reg <= 2'h0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wake_irq_reg <= 1'b0;
      wake_wdt_reg <= 1'b0;
    end else if (state_next == PCG_ST_WAKE && state_reg != PCG_ST_WAKE) begin
      wake_irq_reg <= irq_pending | held_irq_reg;
      wake_wdt_reg <= watchdog_timer_timeout;
    end
  end

  // source captured at entry and driven back out until the next entry
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      source_reg <= 3'h0;
    end else if (state_reg == PCG_ST_RUN && power_save_instruction) begin
      source_reg <= clock_source;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clr_wdt_reg <= 1'b0;
    end else begin
      clr_wdt_reg <= (state_reg == PCG_ST_RUN) & power_save_instruction & watchdog_timer_enable;
    end
  end

  // ***************************************
  // clock and oscillator outputs
  // ***************************************
  assign cpu_halted   = (state_reg != PCG_ST_RUN);
  assign cpu_clk_en   = ~cpu_halted & (~slowdown_reg | doze_tick);
  assign resume_to_isr        = wake_irq_reg;
  assign resume_clock_source  = source_reg;
  assign watchdog_timer_clear = clr_wdt_reg;
  assign system_osc_en        = (state_reg != PCG_ST_SLEEP);
  assign periph_clk_en        = (state_reg != PCG_ST_SLEEP);
  assign clock_fail_monitor_active = clock_fail_monitor_enable & (state_reg != PCG_ST_SLEEP);
  assign low_power_rc_oscillator_en = watchdog_timer_enable | clock_fail_monitor_active;

  // ***************************************
  // module gating
  // ***************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gate_reg <= PCG_GATE_RESET;
    end else if (wr_gate) begin
      if (byteenable[0]) begin
        gate_reg[7:0] <= writedata[7:0] & PCG_GATE_WMASK[7:0];
      end
      if (byteenable[1]) begin
        gate_reg[15:8] <= writedata[15:8] & PCG_GATE_WMASK[15:8];
      end
    end
  end

  // one instruction cycle equals one clock here, hence a single stage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gate_eff_reg <= PCG_GATE_RESET;
    end else begin
      gate_eff_reg <= gate_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_mod
      assign module_clock_en[gi] = PRESENT_MASK[gi] & ~gate_eff_reg[gi] & periph_clk_en;
      assign module_regs_en[gi]  = PRESENT_MASK[gi] & ~gate_eff_reg[gi];
      // zero means analog; a gated adc forces every shared pin digital
      assign analog_input_pins[gi] = ~analog_pin_config_bits[gi] &
                                     ~gate_eff_reg[PCG_ADC_GATE_BIT];
    end
  endgenerate

  // ***************************************
  // assertions
  // ***************************************
  sleep_clocks_off_a: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_SLEEP |-> !system_osc_en && !periph_clk_en && !cpu_clk_en)
    else $error("clocks running in sleep");
  idle_cpu_halt_a: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_IDLE |-> !cpu_clk_en && periph_clk_en && system_osc_en)
    else $error("idle clocks wrong");
  monitor_sleep_a: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_SLEEP |-> !clock_fail_monitor_active)
    else $error("monitor active in sleep");
  rc_osc_wdt_a: assert property (@(posedge clock) disable iff (!nrst)
    watchdog_timer_enable |-> low_power_rc_oscillator_en)
    else $error("rc oscillator off with watchdog");
  wdt_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_RUN && power_save_instruction && watchdog_timer_enable
      |=> watchdog_timer_clear && state_reg == PCG_ST_ENTER)
    else $error("watchdog not cleared at entry");
  wake_delay_a: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_IDLE && wake_event |-> ##[2:4] cpu_clk_en || slowdown_reg)
    else $error("idle wake delay out of range");
  held_irq_wake_a: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_ENTER && irq_pending |=> ##1 state_reg == PCG_ST_WAKE)
    else $error("held interrupt lost");
  source_keep_a: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_RUN && power_save_instruction |=>
      resume_clock_source == $past(clock_source))
    else $error("clock source not kept");
  restore_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    restore_reg && irq_pending |=> !slowdown_reg)
    else $error("slowdown not cleared by interrupt");
  doze_rate_a: assert property (@(posedge clock) disable iff (!nrst)
    slowdown_reg && ratio_reg == 3'h1 && !cpu_halted && cpu_clk_en && $stable(ratio_reg)
      |=> !cpu_clk_en || !slowdown_reg || cpu_halted)
    else $error("doze ratio not honoured");
  gate_delay_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_gate && byteenable[0] && writedata[PCG_ADC_GATE_BIT] |=> ##1 !module_regs_en[PCG_ADC_GATE_BIT])
    else $error("gate not applied after one cycle");
  adc_digital_a: assert property (@(posedge clock) disable iff (!nrst)
    gate_eff_reg[PCG_ADC_GATE_BIT] |-> analog_input_pins == 16'h0000)
    else $error("analog pins active with adc gated");
  monitor_idle_a: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_IDLE && (watchdog_timer_enable || clock_fail_monitor_enable)
      |-> low_power_rc_oscillator_en)
    else $error("rc oscillator off in idle");
  sleep_periph_a: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_SLEEP |-> module_clock_en == 16'h0000)
    else $error("module clocked in sleep");
  entry_halt_a: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_RUN && power_save_instruction |=> cpu_halted && !cpu_clk_en)
    else $error("cpu not halted at entry");
  mode_wake_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == PCG_ST_SLEEP || state_reg == PCG_ST_IDLE) && wake_event |=> state_reg == PCG_ST_WAKE)
    else $error("wake event ignored");
  restore_off_a: assert property (@(posedge clock) disable iff (!nrst)
    !restore_reg && slowdown_reg && !wr_div |=> slowdown_reg)
    else $error("doze left without restore bit");
  gate_bit8_a: assert property (@(posedge clock) disable iff (!nrst)
    !gate_reg[8])
    else $error("unimplemented gate bit set");
  sleep_cov_c: cover property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_SLEEP ##1 state_reg == PCG_ST_WAKE);
  idle_cov_c: cover property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_IDLE ##1 state_reg == PCG_ST_WAKE);
  doze_cov_c: cover property (@(posedge clock) disable iff (!nrst)
    slowdown_reg && restore_reg && irq_pending);
  gate_cov_c: cover property (@(posedge clock) disable iff (!nrst)
    gate_eff_reg[PCG_ADC_GATE_BIT] && !module_clock_en[PCG_ADC_GATE_BIT]);
  coincident_cov_c: cover property (@(posedge clock) disable iff (!nrst)
    state_reg == PCG_ST_ENTER && irq_pending);
endmodule
`default_nettype wire

// File: pcg_cpu_model.sv
// partner: cpu core that issues the power-save instruction and counts its clock enables
`default_nettype none
module pcg_cpu_model (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          nrst,
  // bench commands
  input  wire logic          exec,
  input  wire logic          mode_sel,
  // block side
  input  wire logic          cpu_clk_en,
  input  wire logic          cpu_halted,
  output logic               power_save_instruction,
  output pcg_pkg::pcg_mode_t power_save_mode,
  output logic [15:0]        tick_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcg_pkg::*;
  // a halted or unclocked core cannot execute, so no pulse then
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      power_save_instruction <= 1'h0;
      power_save_mode        <= PCG_MODE_SLEEP;
    end else begin
      power_save_instruction <= exec & cpu_clk_en & ~cpu_halted;
      if (exec) begin
        power_save_mode <= pcg_mode_t'(mode_sel);
      end
    end
  end
  // instruction cycles actually granted to the core
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 16'h0000;
    end else if (cpu_clk_en) begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// testbench: register bus, doze, sleep, idle and module gating of the clock manager
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pcg_pkg::*;
  // ****
  // signals
  // ****
  logic        clock, nrst, read, write, exec, mode_sel, irq_pending, cpu_clk_en, cpu_halted;
  logic        watchdog_timer_enable, watchdog_timer_timeout, clock_fail_monitor_enable;
  logic        power_save_instruction, waitrequest, resume_to_isr, watchdog_timer_clear;
  logic        system_osc_en, low_power_rc_oscillator_en, clock_fail_monitor_active, periph_clk_en;
  logic [3:0]  address, byteenable, be_sel;
  logic [31:0] writedata, readdata, q;
  logic [2:0]  clock_source, resume_clock_source;
  logic [15:0] module_clock_en, module_regs_en, analog_pin_config_bits, analog_input_pins;
  logic [15:0] tick_cnt, t;
  pcg_mode_t   power_save_mode;
  int          n_fail, compares, n;
  pcg_power_save_clock_gating dut_u (.clock, .nrst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .power_save_instruction, .power_save_mode,
    .irq_pending, .clock_source, .cpu_clk_en, .cpu_halted, .resume_to_isr, .resume_clock_source,
    .watchdog_timer_enable, .watchdog_timer_timeout, .clock_fail_monitor_enable,
    .watchdog_timer_clear, .system_osc_en, .low_power_rc_oscillator_en, .clock_fail_monitor_active,
    .periph_clk_en, .module_clock_en, .module_regs_en, .analog_pin_config_bits, .analog_input_pins);
  pcg_cpu_model cpu_u (.clock, .nrst, .exec, .mode_sel, .cpu_clk_en, .cpu_halted,
    .power_save_instruction, .power_save_mode, .tick_cnt);
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  // ****
  // shared tasks
  // ****
  task automatic finish_test;
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is sampled low at an edge; data taken and request released there
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
    int i;
    rd = 32'h0;
    @(posedge clock);
    address    <= a;
    writedata  <= d;
    byteenable <= be_sel;
    write      <= wr;
    read       <= ~wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (waitrequest === 1'h0) break;
    end
    if (i == 20) begin
      n_fail++;
      finish_test();
    end
    rd = readdata;
    write <= 1'h0;
    read  <= 1'h0;
  endtask
  task automatic enter(input logic md, input logic coin);
    @(posedge clock);
    exec     <= 1'h1;
    mode_sel <= md;
    @(posedge clock);
    exec <= 1'h0;
    @(posedge clock);
    irq_pending <= coin;
    #1 chk(watchdog_timer_clear, watchdog_timer_enable);
    chk(cpu_halted, 1'h1);
    @(posedge clock);
    irq_pending <= 1'h0;
    #1;
  endtask
  task automatic wake(input logic by_irq, output int cnt);
    @(posedge clock);
    if (by_irq) irq_pending <= 1'h1;
    else watchdog_timer_timeout <= 1'h1;
    for (cnt = 0; cnt < 20; ) begin
      @(posedge clock);
      irq_pending            <= 1'h0;
      watchdog_timer_timeout <= 1'h0;
      cnt++;
      #1 if (cpu_halted === 1'h0) break;
    end
    if (cnt == 20) begin
      n_fail++;
      finish_test();
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_regs;
    #1 chk(module_clock_en, 16'hfeff);
    bus(1'h0, PCG_GATE_ONE_OFS, 32'h0, q);
    chk(q, 32'h0);
    bus(1'h0, PCG_CLOCK_DIVIDER_OFS, 32'h0, q);
    chk(q[14:12], 3'h0);
    bus(1'h1, PCG_GATE_ONE_OFS, 32'hffff, q);
    #1 chk(module_regs_en, 16'hfeff);
    @(posedge clock);
    #1 chk(module_regs_en, 16'h0);
    chk(module_clock_en, 16'h0);
    chk(analog_input_pins, 16'h0);
    bus(1'h0, PCG_GATE_ONE_OFS, 32'h0, q);
    chk(q, 32'hfeff);
    be_sel = 4'h2;
    bus(1'h1, PCG_GATE_ONE_OFS, 32'h0201, q);
    be_sel = 4'hf;
    @(posedge clock);
    #1 chk(module_clock_en, 16'hfc00);
    bus(1'h1, 4'hc, 32'hffff, q);
    bus(1'h0, 4'hc, 32'h0, q);
    chk(q, 32'h0);
    bus(1'h1, PCG_GATE_ONE_OFS, 32'h0, q);
    @(posedge clock);
    #1 chk(analog_input_pins, 16'hff0f);
  endtask
  task automatic test_doze;
    for (int r = 0; r < 8; r++) begin
      bus(1'h1, PCG_CLOCK_DIVIDER_OFS, 32'h0800 | (r << 12), q);
      repeat (128) @(posedge clock);
      #1 t = tick_cnt;
      repeat (256) @(posedge clock);
      #1 chk(tick_cnt - t, 32'h100 >> r);
      chk(periph_clk_en, 1'h1);
    end
    bus(1'h1, PCG_CLOCK_DIVIDER_OFS, 32'h0, q);
  endtask
  task automatic test_restore;
    for (int i = 0; i < 2; i++) begin
      bus(1'h1, PCG_CLOCK_DIVIDER_OFS, i ? 32'h2800 : 32'ha800, q);
      @(posedge clock);
      irq_pending <= 1'h1;
      repeat (3) @(posedge clock);
      irq_pending <= 1'h0;
      #1 t = tick_cnt;
      repeat (8) @(posedge clock);
      #1 chk(tick_cnt - t, i ? 32'h2 : 32'h8);
      bus(1'h0, PCG_CLOCK_DIVIDER_OFS, 32'h0, q);
      chk(q[11], i[0]);
    end
    bus(1'h1, PCG_CLOCK_DIVIDER_OFS, 32'h0, q);
  endtask
  task automatic test_sleep;
    watchdog_timer_enable     <= 1'h1;
    clock_fail_monitor_enable <= 1'h1;
    enter(1'h0, 1'h0);
    chk({system_osc_en, periph_clk_en, clock_fail_monitor_active, low_power_rc_oscillator_en,
         cpu_clk_en, cpu_halted}, 6'h05);
    chk(module_clock_en, 16'h0);
    clock_source <= 3'h2;
    wake(1'h0, n);
    chk(resume_clock_source, 3'h5);
    chk(resume_to_isr, 1'h0);
    bus(1'h0, PCG_STATUS_OFS, 32'h0, q);
    chk(q[PCG_ST_WAKE_WDT_BIT], 1'h1);
  endtask
  // second pass raises the interrupt during entry: held, so the wait is one shorter
  task automatic test_idle;
    for (int i = 0; i < 2; i++) begin
      watchdog_timer_enable <= i[0];
      enter(1'h1, i[0]);
      chk({system_osc_en, periph_clk_en, clock_fail_monitor_active, low_power_rc_oscillator_en,
           cpu_clk_en, cpu_halted}, 6'h3d);
      chk(module_clock_en, 16'hfeff);
      wake(1'h1, n);
      chk(n, i ? 32'h3 : 32'h4);
      chk(resume_to_isr, 1'h1);
    end
  endtask
  task automatic test_reset_wake;
    bus(1'h1, PCG_GATE_ONE_OFS, 32'h0001, q);
    enter(1'h0, 1'h0);
    @(posedge clock);
    nrst <= 1'h0;
    #1 chk(cpu_halted, 1'h0);
    chk(system_osc_en, 1'h1);
    chk(module_clock_en, 16'hfeff);
    repeat (2) @(posedge clock);
    nrst <= 1'h1;
    bus(1'h0, PCG_GATE_ONE_OFS, 32'h0, q);
    chk(q, 32'h0);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    nrst = 1'h0;
    read = 1'h0;
    write = 1'h0;
    exec = 1'h0;
    mode_sel = 1'h0;
    irq_pending = 1'h0;
    address = 4'h0;
    byteenable = 4'hf;
    be_sel = 4'hf;
    writedata = 32'h0;
    watchdog_timer_enable = 1'h0;
    watchdog_timer_timeout = 1'h0;
    clock_fail_monitor_enable = 1'h0;
    clock_source = 3'h5;
    analog_pin_config_bits = 16'h00f0;
    n_fail = 0;
    compares = 0;
    repeat (2) @(posedge clock);
    nrst <= 1'h1;
    test_regs();
    test_doze();
    test_restore();
    test_sleep();
    test_idle();
    test_reset_wake();
    finish_test();
  end
endmodule
`default_nettype wire
